// file: rtl/dbs_defs.vh
// constants for the drive brake sequencer
// assumes a 20 MHz core clock
`ifndef DBS_DEFS_VH
`define DBS_DEFS_VH
`define DBS_CLK_HZ 20000000
// register byte addresses
`define DBS_A_CTRL 8'h00
`define DBS_A_VON 8'h04
`define DBS_A_VOFF 8'h08
`define DBS_A_PWRDLY 8'h0c
`define DBS_A_ONDLY 8'h10
`define DBS_A_OFFDLY 8'h14
`define DBS_A_PULLT 8'h18
`define DBS_A_PULLD 8'h1c
`define DBS_A_HOLDD 8'h20
`define DBS_A_STAT 8'h24
`define DBS_A_VBUS 8'h28
// control fields
`define DBS_C_RES_EN 0
`define DBS_C_HB_EN 1
`define DBS_C_DRV_REQ 2
// reset values
`define DBS_RST_VON 16'hffff
`define DBS_RST_VOFF 16'hffff
`define DBS_RST_PULLD 7'h64
`define DBS_RST_HOLDD 7'h32
// time base: one millisecond tick
`define DBS_TICK_MS 1
`define DBS_TICK_CYC (`DBS_CLK_HZ / 1000 * `DBS_TICK_MS)
`define DBS_PWM_STEPS 100
`endif

// file: rtl/dbs_top.v
// drive brake sequencer: shunt resistor hysteresis, power-on delay,
// holding brake sequencing with pwm coil drive
// assumes bus voltage code and enable pin from outside, register port on I_CLK
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "dbs_defs.vh"
module dbs_top #(
   parameter VW = 16,
   parameter TICK_CYC = `DBS_TICK_CYC
)(
   input wire I_CLK,
   input wire I_RESET,
   input wire [7:0] I_ADDR,
   input wire [31:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   output reg [31:0] O_RDATA,
   input wire [VW-1:0] I_VBUS,
   input wire I_ENABLE_PIN,
   output reg O_RESISTOR_ON,
   output reg O_HOLDING_BRAKE_OUTPUT,
   output reg O_STAGE_ON
);
   localparam S_OFF = 5'h01;
   localparam S_ONDLY = 5'h02;
   localparam S_RUN = 5'h04;
   localparam S_OFFDLY = 5'h08;
   localparam S_PWRUP = 5'h10;
   reg [2:0] ctrl_r;
   reg [VW-1:0] von_r;
   reg [VW-1:0] voff_r;
   reg [15:0] pwrdly_r;
   reg [15:0] ondly_r;
   reg [15:0] offdly_r;
   reg [15:0] pullt_r;
   reg [6:0] pulld_r;
   reg [6:0] holdd_r;
   reg en_s1_r;
   reg en_s2_r;
   reg [VW-1:0] vb_s1_r;
   reg [VW-1:0] vb_s2_r;
   reg [31:0] tick_cnt_r;
   reg tick_r;
   reg [15:0] pwr_cnt_r;
   reg pwr_done_r;
   reg [4:0] state_r;
   reg [4:0] state_nxt;
   reg [15:0] dly_cnt_r;
   reg coil_on_r;
   reg [15:0] pull_cnt_r;
   reg [6:0] pwm_cnt_r;
   wire want_run;
   wire dly_done;
   wire pulling;
   wire [6:0] duty;
   // registers; reads answer one cycle later, unmapped reads zero
   always @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         ctrl_r <= 3'h0;
         von_r <= `DBS_RST_VON;
         voff_r <= `DBS_RST_VOFF;
         pwrdly_r <= 16'h0000;
         ondly_r <= 16'h0000;
         offdly_r <= 16'h0000;
         pullt_r <= 16'h0000;
         pulld_r <= `DBS_RST_PULLD;
         holdd_r <= `DBS_RST_HOLDD;
         O_RDATA <= 32'h00000000;
      end
      else
      begin
         if (I_WR)
         begin
            if (I_ADDR == `DBS_A_CTRL)
               ctrl_r <= I_WDATA[2:0];
            else if (I_ADDR == `DBS_A_VON)
               von_r <= I_WDATA[VW-1:0];
            else if (I_ADDR == `DBS_A_VOFF)
               voff_r <= I_WDATA[VW-1:0];
            else if (I_ADDR == `DBS_A_PWRDLY)
               pwrdly_r <= I_WDATA[15:0];
            else if (I_ADDR == `DBS_A_ONDLY)
               ondly_r <= I_WDATA[15:0];
            else if (I_ADDR == `DBS_A_OFFDLY)
               offdly_r <= I_WDATA[15:0];
            else if (I_ADDR == `DBS_A_PULLT)
               pullt_r <= I_WDATA[15:0];
            // percentages above 100 are clipped to full duty
            else if (I_ADDR == `DBS_A_PULLD)
               pulld_r <= (I_WDATA[6:0] > 7'h64) ? 7'h64 : I_WDATA[6:0];
            else if (I_ADDR == `DBS_A_HOLDD)
               holdd_r <= (I_WDATA[6:0] > 7'h64) ? 7'h64 : I_WDATA[6:0];
         end
         O_RDATA <= 32'h00000000;
         if (I_RD)
         begin
            if (I_ADDR == `DBS_A_CTRL)
               O_RDATA <= {29'h0, ctrl_r};
            else if (I_ADDR == `DBS_A_VON)
               O_RDATA <= {{(32-VW){1'b0}}, von_r};
            else if (I_ADDR == `DBS_A_VOFF)
               O_RDATA <= {{(32-VW){1'b0}}, voff_r};
            else if (I_ADDR == `DBS_A_PWRDLY)
               O_RDATA <= {16'h0, pwrdly_r};
            else if (I_ADDR == `DBS_A_ONDLY)
               O_RDATA <= {16'h0, ondly_r};
            else if (I_ADDR == `DBS_A_OFFDLY)
               O_RDATA <= {16'h0, offdly_r};
            else if (I_ADDR == `DBS_A_PULLT)
               O_RDATA <= {16'h0, pullt_r};
            else if (I_ADDR == `DBS_A_PULLD)
               O_RDATA <= {25'h0, pulld_r};
            else if (I_ADDR == `DBS_A_HOLDD)
               O_RDATA <= {25'h0, holdd_r};
            else if (I_ADDR == `DBS_A_STAT)
               O_RDATA <= {24'h0, pwr_done_r, en_s2_r, O_STAGE_ON,
                  O_HOLDING_BRAKE_OUTPUT, O_RESISTOR_ON, coil_on_r, pulling, 1'b0};
            else if (I_ADDR == `DBS_A_VBUS)
               O_RDATA <= {{(32-VW){1'b0}}, vb_s2_r};
         end
      end
   end
   // pin inputs pass two flops; bus voltage assumed slow against the clock
   always @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         en_s1_r <= 1'b0;
         en_s2_r <= 1'b0;
         vb_s1_r <= {VW{1'b0}};
         vb_s2_r <= {VW{1'b0}};
      end
      else
      begin
         en_s1_r <= I_ENABLE_PIN;
         en_s2_r <= en_s1_r;
         vb_s1_r <= I_VBUS;
         vb_s2_r <= vb_s1_r;
      end
   end
   // shunt resistor with hysteresis
   always @(posedge I_CLK)
   begin
      if (I_RESET)
         O_RESISTOR_ON <= 1'b0;
      else if (!ctrl_r[`DBS_C_RES_EN])
         O_RESISTOR_ON <= 1'b0;
      else if (!O_RESISTOR_ON && vb_s2_r >= von_r)
         O_RESISTOR_ON <= 1'b1;
      else if (O_RESISTOR_ON && vb_s2_r <= voff_r)
         O_RESISTOR_ON <= 1'b0;
      // otherwise hold
   end
   // millisecond tick shared by all delays
   always @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         tick_cnt_r <= 32'h0;
         tick_r <= 1'b0;
      end
      else if (tick_cnt_r == TICK_CYC - 1)
      begin
         tick_cnt_r <= 32'h0;
         tick_r <= 1'b1;
      end
      else
      begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
         tick_r <= 1'b0;
      end
   end
   // power-on hold-off, counts from reset release
   // not latched: the delay register is only written after reset, and a
   // latch would fire on its zero reset value before software sets it
   always @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         pwr_cnt_r <= 16'h0;
         pwr_done_r <= 1'b0;
      end
      else
      begin
         if (tick_r && pwr_cnt_r != 16'hffff)
            pwr_cnt_r <= pwr_cnt_r + 16'h1;
         pwr_done_r <= (pwr_cnt_r >= pwrdly_r);
      end
   end
   assign want_run = ctrl_r[`DBS_C_DRV_REQ] && en_s2_r && pwr_done_r;
   // brake bypass makes both delays zero
   assign dly_done = !ctrl_r[`DBS_C_HB_EN] ||
      (dly_cnt_r >= ((state_r == S_ONDLY) ? ondly_r : offdly_r));
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         S_PWRUP:
            if (pwr_done_r)
               state_nxt = S_OFF;
         S_OFF:
            if (want_run)
               state_nxt = S_ONDLY;
         S_ONDLY:
            if (!want_run)
               state_nxt = S_OFF;
            else if (dly_done)
               state_nxt = S_RUN;
         S_RUN:
            if (!want_run)
               state_nxt = S_OFFDLY;
         S_OFFDLY:
            if (dly_done)
               state_nxt = S_OFF;
         default:
            state_nxt = S_OFF;
      endcase
   end
   always @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         state_r <= S_PWRUP;
         dly_cnt_r <= 16'h0;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_nxt != state_r)
            dly_cnt_r <= 16'h0;
         else if (tick_r && dly_cnt_r != 16'hffff)
            dly_cnt_r <= dly_cnt_r + 16'h1;
      end
   end
   // coil energised releases the brake; pull-in then hold
   always @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         coil_on_r <= 1'b0;
         pull_cnt_r <= 16'h0;
         O_STAGE_ON <= 1'b0;
      end
      else
      begin
         coil_on_r <= ctrl_r[`DBS_C_HB_EN] && (state_nxt == S_RUN);
         O_STAGE_ON <= (state_nxt == S_ONDLY) || (state_nxt == S_RUN) ||
            (state_nxt == S_OFFDLY);
         if (!coil_on_r)
            pull_cnt_r <= 16'h0;
         else if (tick_r && pulling)
            pull_cnt_r <= pull_cnt_r + 16'h1;
      end
   end
   assign pulling = coil_on_r && (pull_cnt_r < pullt_r);
   assign duty = pulling ? pulld_r : holdd_r;
   // pwm period of 100 steps so duty equals percent directly
   always @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         pwm_cnt_r <= 7'h0;
         O_HOLDING_BRAKE_OUTPUT <= 1'b0;
      end
      else
      begin
         if (pwm_cnt_r == `DBS_PWM_STEPS - 1)
            pwm_cnt_r <= 7'h0;
         else
            pwm_cnt_r <= pwm_cnt_r + 7'h1;
         O_HOLDING_BRAKE_OUTPUT <= coil_on_r && (pwm_cnt_r < duty);
      end
   end
endmodule // dbs_top
`default_nettype wire

// file: tb/dbs_top_assertions.sv
// checker for dbs_top, bound to its ports
// assumes a ms tick of at least 8 cycles
`timescale 1ns/100ps
`default_nettype none
module dbs_chk #(
   parameter VW = 16,
   parameter TICK_CYC = 20000
)(
   input wire I_CLK,
   input wire I_RESET,
   input wire [7:0] I_ADDR,
   input wire [31:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   input wire [31:0] O_RDATA,
   input wire [VW-1:0] I_VBUS,
   input wire I_ENABLE_PIN,
   input wire O_RESISTOR_ON,
   input wire O_HOLDING_BRAKE_OUTPUT,
   input wire O_STAGE_ON
);
   reg [1:0] en_r;
   reg [VW-1:0] von_r;
   reg [VW-1:0] voff_r;
   reg [31:0] dly_r;
   // shadow of the settings, taken at the write edge
   always @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         en_r <= 2'h0;
         von_r <= {VW{1'b1}};
         voff_r <= {VW{1'b1}};
         dly_r <= 32'h0;
      end
      else if (I_WR)
      begin
         if (I_ADDR == 8'h00) en_r <= I_WDATA[1:0];
         if (I_ADDR == 8'h04) von_r <= I_WDATA[VW-1:0];
         if (I_ADDR == 8'h08) voff_r <= I_WDATA[VW-1:0];
         if (I_ADDR == 8'h10) dly_r <= I_WDATA;
      end
   end
   default clocking @(posedge I_CLK); endclocking
   default disable iff (I_RESET);
   property p_res_dis;
      (!en_r[0])[*3] |-> !O_RESISTOR_ON;
   endproperty
   a_res_dis: assert property (p_res_dis) else $error("shunt on while off");
   property p_res_on;
      (en_r[0] && von_r > voff_r && I_VBUS >= von_r)[*5] |-> O_RESISTOR_ON;
   endproperty
   a_res_on: assert property (p_res_on) else $error("shunt not on");
   property p_res_off;
      (von_r > voff_r && I_VBUS <= voff_r)[*5] |-> !O_RESISTOR_ON;
   endproperty
   a_res_off: assert property (p_res_off) else $error("shunt not off");
   property p_res_hold;
      (en_r[0] && I_VBUS > voff_r && I_VBUS < von_r)[*5] |-> $stable(O_RESISTOR_ON);
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("shunt moved");
   property p_hb_dis;
      (!en_r[1])[*3] |-> !O_HOLDING_BRAKE_OUTPUT;
   endproperty
   a_hb_dis: assert property (p_hb_dis) else $error("coil driven");
   // an on-delay of one tick may round to nothing
   property p_ondly;
      $rose(O_STAGE_ON) && dly_r > 32'h1 |-> (!O_HOLDING_BRAKE_OUTPUT)[*8];
   endproperty
   a_ondly: assert property (p_ondly) else $error("brake freed early");
   property p_coil_stage;
      !O_STAGE_ON |-> !O_HOLDING_BRAKE_OUTPUT;
   endproperty
   a_coil_stage: assert property (p_coil_stage) else $error("coil without stage");
   property p_coil_pin;
      (!I_ENABLE_PIN)[*6] |-> !O_HOLDING_BRAKE_OUTPUT;
   endproperty
   a_coil_pin: assert property (p_coil_pin) else $error("coil without enable");
endmodule // dbs_chk
bind dbs_top dbs_chk #(.VW(VW), .TICK_CYC(TICK_CYC)) u_chk (
   .I_CLK(I_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
   .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_VBUS(I_VBUS),
   .I_ENABLE_PIN(I_ENABLE_PIN), .O_RESISTOR_ON(O_RESISTOR_ON),
   .O_HOLDING_BRAKE_OUTPUT(O_HOLDING_BRAKE_OUTPUT), .O_STAGE_ON(O_STAGE_ON));
`default_nettype wire

// file: tb/dbs_coil_model.sv
// brake coil stand-in: measures each pwm pulse
// assumes the coil is sampled on the core clock
`timescale 1ns/100ps
`default_nettype none
module dbs_coil_model (
   input wire logic i_clk,
   input wire logic i_coil,
   output logic [7:0] o_width,
   output logic [7:0] o_pulses
);
   logic [7:0] run;
   initial
   begin
      run = 8'h00;
      o_width = 8'h00;
      o_pulses = 8'h00;
   end
   always @(posedge i_clk)
   begin
      run <= i_coil ? run + 8'h01 : 8'h00;
      if (!i_coil && run != 8'h00)
      begin
         o_width <= run;
         o_pulses <= o_pulses + 8'h01;
      end
   end
endmodule // dbs_coil_model
`default_nettype wire

// file: tb/drive_brake_sequencer_test.sv
// self-checking bench for the drive brake sequencer
// assumes a 100-cycle ms tick so delays stay short
`timescale 1ns/100ps
`default_nettype none
module drive_brake_sequencer_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic pin = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [15:0] vbus = 16'h0;
   wire [31:0] rdata;
   wire res_on;
   wire coil;
   wire stage;
   wire [7:0] width;
   wire [7:0] pulses;
   int miscompares = 0;
   int compares = 0;
   int n = 0;
   always #25 clk = ~clk;
   dbs_top #(.TICK_CYC(100)) u_dut (.I_CLK(clk), .I_RESET(rst), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_VBUS(vbus),
      .I_ENABLE_PIN(pin), .O_RESISTOR_ON(res_on), .O_HOLDING_BRAKE_OUTPUT(coil),
      .O_STAGE_ON(stage));
   dbs_coil_model u_coil (.i_clk(clk), .i_coil(coil), .o_width(width), .o_pulses(pulses));
   task automatic final_report;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tmo;
      @(negedge clk);
      n++;
      if (n > 900)
      begin
         miscompares++;
         final_report;
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   // shunt output three cycles behind the bus code
   task automatic step(input logic [15:0] v, input logic e);
      @(posedge clk);
      vbus <= v;
      repeat (6) @(posedge clk);
      #1 chk({31'h0, res_on}, {31'h0, e});
   endtask
   task automatic t_power;
      rreg(8'h1c, 32'h64);
      rreg(8'h04, 32'hffff);
      rreg(8'h3c, 32'h0);
      wreg(8'h0c, 32'h3);
      wreg(8'h10, 32'h2);
      wreg(8'h14, 32'h2);
      wreg(8'h18, 32'h3);
      wreg(8'h1c, 32'h50);
      wreg(8'h20, 32'h1e);
      wreg(8'h00, 32'h6);
      pin <= 1'b1;
      repeat (100) @(posedge clk);
      rreg(8'h24, 32'h40);
      n = 0;
      while (stage !== 1'b1) tmo;
   endtask
   task automatic t_brake;
      n = 0;
      while (coil !== 1'b1) tmo;
      chk(n >= 90, 32'h1);
      n = 0;
      while (pulses !== 8'h02) tmo;
      chk(width, 32'h50);
      repeat (500) @(negedge clk);
      chk(width, 32'h1e);
   endtask
   task automatic t_off;
      pin <= 1'b0;
      repeat (10) @(negedge clk);
      chk({coil, stage}, 32'h1);
      n = 0;
      while (stage !== 1'b0) tmo;
      chk(n >= 80, 32'h1);
   endtask
   task automatic t_hb_dis;
      logic [7:0] p0;
      p0 = pulses;
      wreg(8'h00, 32'h4);
      pin <= 1'b1;
      n = 0;
      while (stage !== 1'b1) tmo;
      repeat (400) tmo;
      chk(pulses, p0);
      pin <= 1'b0;
      n = 0;
      while (stage !== 1'b0) tmo;
      chk(n < 10, 32'h1);
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_power;
      t_brake;
      t_off;
      t_hb_dis;
      wreg(8'h04, 32'hc8);
      wreg(8'h08, 32'h64);
      wreg(8'h00, 32'h1);
      step(16'h96, 1'b0);
      step(16'hc8, 1'b1);
      step(16'h96, 1'b1);
      step(16'h64, 1'b0);
      step(16'hfa, 1'b1);
      wreg(8'h00, 32'h0);
      step(16'hfa, 1'b0);
      wreg(8'h04, 32'hffff);
      wreg(8'h08, 32'hffff);
      wreg(8'h00, 32'h1);
      step(16'hfffe, 1'b0);
      final_report;
   end
endmodule // drive_brake_sequencer_test
`default_nettype wire
